/* File: logic/mef_params.svh */
// Notes on behaviour
// - Page select bit 0 routes accesses to page 0, 1 to page 1.
// - Soft reset write of 1 restores all registers; 0 does nothing.
// - Current event after code+1 consecutive high samples at clock/4.
// - Each PWM turn-on starts a current blank of code times 0.5us.
// - While current blank runs, comparator samples are masked.
// - Demag event needs code+1 straight samples; not in sensor mode.
// - Each commutation starts demag blank: 5us..40us, then 60us..200us.
// - In sensor mode no demag blank follows a commutation.
// - Blank times assume 4 MHz; windows count clock cycles and scale.
// - Sensorless samples demag at PWM rate unless high-rate sampling set.
`ifndef MEF_PARAMS_SVH
`define MEF_PARAMS_SVH

`define MEF_OFS_CUR_CFG 8'h00
`define MEF_OFS_DEMAG_CFG 8'h04
`define MEF_OFS_MODE 8'h08
`define MEF_OFS_STATUS 8'h0c

`define MEF_CUR_CFG_RST 8'h00
`define MEF_DEMAG_CFG_RST 8'h0f
`define MEF_MODE_RST 8'h00

`define MEF_PAGE_BIT 7
`define MEF_SOFT_RST_BIT 6
`define MEF_CUR_CNT_LSB 3
`define MEF_CUR_BLANK_LSB 0
`define MEF_DEMAG_CNT_LSB 4
`define MEF_DEMAG_BLANK_LSB 0
`define MEF_MODE_SENSOR_BIT 0
`define MEF_MODE_HF_BIT 1

`define MEF_REF_CLK_KHZ 4000
`define MEF_CUR_BLANK_STEP_NS 500
`define MEF_DEMAG_STEP_LO_NS 5000
`define MEF_DEMAG_BASE_HI_NS 40000
`define MEF_DEMAG_STEP_HI_NS 20000
`define MEF_CUR_BLANK_STEP_CYC \
  ((`MEF_CUR_BLANK_STEP_NS * `MEF_REF_CLK_KHZ) / 1000000)
`define MEF_DEMAG_STEP_LO_CYC \
  ((`MEF_DEMAG_STEP_LO_NS * `MEF_REF_CLK_KHZ) / 1000000)
`define MEF_DEMAG_BASE_HI_CYC \
  ((`MEF_DEMAG_BASE_HI_NS * `MEF_REF_CLK_KHZ) / 1000000)
`define MEF_DEMAG_STEP_HI_CYC \
  ((`MEF_DEMAG_STEP_HI_NS * `MEF_REF_CLK_KHZ) / 1000000)
`define MEF_CUR_SAMPLE_DIV 4

`endif

/* File: logic/mef_pkg.sv */
package mef_pkg;
  typedef enum logic [1:0] {
    MEF_RESP_OKAY = 2'b00,
    MEF_RESP_SLVERR = 2'b10
  } mef_resp_type;

  typedef enum logic {
    MEF_WR_COLLECT = 1'b0,
    MEF_WR_RESP = 1'b1
  } mef_wr_state_type;

  typedef enum logic [2:0] {
    MEF_REG_CUR = 3'b000,
    MEF_REG_DEMAG = 3'b001,
    MEF_REG_MODE = 3'b010,
    MEF_REG_STATUS = 3'b011,
    MEF_REG_NONE = 3'b111
  } mef_reg_type;
endpackage

/* File: logic/mef_consec_filter.sv */
`timescale 1ns/1ps
module mef_consec_filter #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic clear,
  input wire logic bypass,
  input wire logic [WIDTH-1:0] count_code,
  // Samples
  input wire logic sample_stb,
  input wire logic sample_val,
  // Result
  output logic event_q
);
  logic [WIDTH-1:0] run_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear || bypass) begin
      run_q <= '0;
    end else if (sample_stb) begin
      if (!sample_val) begin
        run_q <= '0;
      end else if (run_q != count_code) begin
        run_q <= run_q + 1'b1;
      end
    end
  end

  // Bypass follows the input directly, without waiting for a strobe
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      event_q <= 1'b0;
    end else if (bypass) begin
      event_q <= sample_val;
    end else if (sample_stb) begin
      event_q <= sample_val && (run_q == count_code);
    end
  end
endmodule

/* File: logic/mef_blank_window.sv */
`timescale 1ns/1ps
module mef_blank_window (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic clear,
  input wire logic start,
  input wire logic [9:0] len_cyc,
  // Window
  output logic active_q
);
  logic [9:0] left_q;

  // A restart during a window reloads the full length
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      left_q <= 10'h000;
    end else if (start) begin
      left_q <= len_cyc;
    end else if (left_q != 10'h000) begin
      left_q <= left_q - 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      active_q <= 1'b0;
    end else if (start) begin
      active_q <= (len_cyc != 10'h000);
    end else begin
      active_q <= (left_q > 10'h001);
    end
  end
endmodule

/* File: logic/mef_top.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mef_params.svh"
module mef_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output mef_pkg::mef_resp_type s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output mef_pkg::mef_resp_type s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Comparator pins
  input wire logic cur_cmp_in,
  input wire logic demag_cmp_in,
  // Motor timing strobes from same-clock logic
  input wire logic pwm_on_evt,
  input wire logic comm_evt,
  input wire logic pwm_off_end_evt,
  input wire logic hf_sample_tick,
  // Results
  output logic page_select,
  output logic motor_regs_rst,
  output logic cur_limit_evt,
  output logic demag_evt,
  output logic cur_blank_active,
  output logic demag_blank_active
);
  import mef_pkg::*;

  // Register decode
  function automatic mef_reg_type reg_decode(input logic [7:0] addr);
    case ({addr[7:2], 2'b00})
      `MEF_OFS_CUR_CFG: reg_decode = MEF_REG_CUR;
      `MEF_OFS_DEMAG_CFG: reg_decode = MEF_REG_DEMAG;
      `MEF_OFS_MODE: reg_decode = MEF_REG_MODE;
      `MEF_OFS_STATUS: reg_decode = MEF_REG_STATUS;
      default: reg_decode = MEF_REG_NONE;
    endcase
  endfunction

  // Blank lengths counted in clock cycles, figures set for a 4 MHz clock
  function automatic logic [9:0] cur_blank_cyc(input logic [2:0] code);
    cur_blank_cyc = 10'({29'h0, code} * `MEF_CUR_BLANK_STEP_CYC);
  endfunction

  function automatic logic [9:0] demag_blank_cyc(input logic [3:0] code);
    if (!code[3]) begin
      demag_blank_cyc = 10'(({28'h0, code} + 32'h1) *
        `MEF_DEMAG_STEP_LO_CYC);
    end else begin
      demag_blank_cyc = 10'(({28'h0, code} - 32'h7) *
        `MEF_DEMAG_STEP_HI_CYC + `MEF_DEMAG_BASE_HI_CYC);
    end
  endfunction

  // Bus state
  mef_wr_state_type wr_state_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic do_write;
  mef_reg_type wr_sel;
  mef_reg_type rd_sel;

  // Registers
  logic [7:0] cur_cfg_q;
  logic [7:0] demag_cfg_q;
  logic [7:0] mode_q;
  logic soft_rst_q;

  // Synchronised comparators
  logic cur_meta_q;
  logic cur_sync_q;
  logic demag_meta_q;
  logic demag_sync_q;

  // Sampling
  logic [1:0] presc_q;
  logic cur_tick_q;
  logic sensor_mode;
  logic demag_stb;

  // Filter and window outputs
  logic cur_evt_w;
  logic demag_evt_w;
  logic cur_blank_w;
  logic demag_blank_w;

  assign wr_sel = reg_decode(awaddr_q);
  assign rd_sel = reg_decode(s_axi_araddr);
  assign do_write = aw_have_q && w_have_q && (wr_state_q == MEF_WR_COLLECT);
  assign sensor_mode = mode_q[`MEF_MODE_SENSOR_BIT];

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= MEF_WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MEF_RESP_OKAY;
    end else begin
      case (wr_state_q)
        MEF_WR_COLLECT: begin
          if (do_write) begin
            wr_state_q <= MEF_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == MEF_REG_NONE) ?
              MEF_RESP_SLVERR : MEF_RESP_OKAY;
          end
        end
        MEF_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= MEF_WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= MEF_WR_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Read channel; data is captured with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= MEF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= MEF_RESP_OKAY;
      case (rd_sel)
        MEF_REG_CUR: s_axi_rdata <= {24'h0, cur_cfg_q};
        MEF_REG_DEMAG: s_axi_rdata <= {24'h0, demag_cfg_q};
        MEF_REG_MODE: s_axi_rdata <= {24'h0, mode_q};
        MEF_REG_STATUS: s_axi_rdata <= {26'h0, demag_sync_q, cur_sync_q,
          demag_blank_active, cur_blank_active, demag_evt, cur_limit_evt};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= MEF_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // Soft reset is a one-cycle pulse; the bit itself never stores
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= do_write && wstrb0_q && (wr_sel == MEF_REG_CUR) &&
        wdata_q[`MEF_SOFT_RST_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_q) begin
      cur_cfg_q <= `MEF_CUR_CFG_RST;
    end else if (do_write && wstrb0_q && (wr_sel == MEF_REG_CUR)) begin
      cur_cfg_q <= wdata_q & ~(8'h01 << `MEF_SOFT_RST_BIT);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_q) begin
      demag_cfg_q <= `MEF_DEMAG_CFG_RST;
    end else if (do_write && wstrb0_q && (wr_sel == MEF_REG_DEMAG)) begin
      demag_cfg_q <= wdata_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_q) begin
      mode_q <= `MEF_MODE_RST;
    end else if (do_write && wstrb0_q && (wr_sel == MEF_REG_MODE)) begin
      mode_q <= wdata_q & 8'h03;
    end
  end

  // Page routing for the rest of the peripheral's register map
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_select <= 1'b0;
      motor_regs_rst <= 1'b0;
    end else begin
      page_select <= cur_cfg_q[`MEF_PAGE_BIT];
      motor_regs_rst <= soft_rst_q;
    end
  end

  // Comparators come from analog pins, so two flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_meta_q <= 1'b0;
      cur_sync_q <= 1'b0;
      demag_meta_q <= 1'b0;
      demag_sync_q <= 1'b0;
    end else begin
      cur_meta_q <= cur_cmp_in;
      cur_sync_q <= cur_meta_q;
      demag_meta_q <= demag_cmp_in;
      demag_sync_q <= demag_meta_q;
    end
  end

  // Current sampling tick at a quarter of the clock
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_q) begin
      presc_q <= 2'b00;
      cur_tick_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 2'b01;
      cur_tick_q <= (presc_q == 2'(`MEF_CUR_SAMPLE_DIV - 1));
    end
  end

  // Demag strobe: PWM rate unless high-rate sampling is on
  assign demag_stb = mode_q[`MEF_MODE_HF_BIT] ?
    hf_sample_tick : pwm_off_end_evt;

  mef_blank_window u_cur_blank (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(soft_rst_q),
    .start(pwm_on_evt),
    .len_cyc(cur_blank_cyc(cur_cfg_q[`MEF_CUR_BLANK_LSB +: 3])),
    .active_q(cur_blank_w)
  );

  mef_blank_window u_demag_blank (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(soft_rst_q || sensor_mode),
    .start(comm_evt && !sensor_mode),
    .len_cyc(demag_blank_cyc(demag_cfg_q[`MEF_DEMAG_BLANK_LSB +: 4])),
    .active_q(demag_blank_w)
  );

  // A masked comparator counts as a failed sample and breaks the run
  mef_consec_filter #(
    .WIDTH(3)
  ) u_cur_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(soft_rst_q),
    .bypass(1'b0),
    .count_code(cur_cfg_q[`MEF_CUR_CNT_LSB +: 3]),
    .sample_stb(cur_tick_q),
    .sample_val(cur_sync_q && !cur_blank_w),
    .event_q(cur_evt_w)
  );

  mef_consec_filter #(
    .WIDTH(4)
  ) u_demag_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(soft_rst_q),
    .bypass(sensor_mode),
    .count_code(demag_cfg_q[`MEF_DEMAG_CNT_LSB +: 4]),
    .sample_stb(demag_stb),
    .sample_val(demag_sync_q && !demag_blank_w),
    .event_q(demag_evt_w)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_limit_evt <= 1'b0;
      demag_evt <= 1'b0;
      cur_blank_active <= 1'b0;
      demag_blank_active <= 1'b0;
    end else begin
      cur_limit_evt <= cur_evt_w;
      demag_evt <= demag_evt_w;
      cur_blank_active <= cur_blank_w;
      demag_blank_active <= demag_blank_w;
    end
  end
endmodule

/* File: testbench/mef_top_assertions.sv */
`timescale 1ns/1ps
module mef_top_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire mef_pkg::mef_resp_type s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mef_pkg::mef_resp_type s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_awready,
  // Motor side
  input wire logic cur_cmp_in,
  input wire logic pwm_on_evt,
  input wire logic comm_evt,
  input wire logic motor_regs_rst,
  input wire logic cur_limit_evt,
  input wire logic demag_evt,
  input wire logic cur_blank_active,
  input wire logic demag_blank_active
);
  import mef_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_reset_idle: assert property ($rose(aresetn) |-> s_axi_awready &&
    !s_axi_bvalid && !s_axi_rvalid && !cur_limit_evt && !demag_evt)
    else $error("outputs not idle after reset");
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_read_hold: assert property (
    s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] != 4'h0
    |=> s_axi_rresp == MEF_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Pin to event is two sync flops, one filter flop and one output flop
  a_cur_cause: assert property (
    $rose(cur_limit_evt) |-> $past(cur_cmp_in, 4))
    else $error("current event without comparator cause");
  a_blank_masks: assert property (
    cur_blank_active [*5] |-> !cur_limit_evt)
    else $error("current event kept through blank");
  a_cur_blank_start: assert property (
    $rose(cur_blank_active) |-> $past(pwm_on_evt, 2))
    else $error("current blank without pwm turn-on");
  a_dm_blank_start: assert property (
    $rose(demag_blank_active) |-> $past(comm_evt, 2))
    else $error("demag blank without commutation");
  a_soft_rst_pulse: assert property (
    motor_regs_rst |=> !cur_limit_evt && !motor_regs_rst)
    else $error("soft reset pulse wrong");
endmodule

/* File: testbench/mef_cmp_model.sv */
`timescale 1ns/1ps
module mef_cmp_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic level,
  input wire logic chatter,
  // Comparator output
  output logic cmp_out
);
  logic [2:0] phase_q;
  // Noise burst: high 2 of 7 cycles, never two adjacent highs at clock/4
  always_ff @(posedge aclk) begin
    if (!aresetn || phase_q == 3'h6) phase_q <= 3'h0;
    else phase_q <= phase_q + 3'h1;
  end
  assign cmp_out = chatter ? (phase_q < 3'h2) : level;
endmodule

/* File: testbench/tb_motor_event_filter_regs.sv */
`timescale 1ns/1ps
module tb_motor_event_filter_regs;
  import mef_pkg::*;
  logic aclk = 0, aresetn = 0, cur_lvl = 0, dm_lvl = 0, chatter = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, d;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0, strb = 0;
  logic lazy = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  mef_resp_type s_axi_bresp, s_axi_rresp;
  logic cur_cmp_in, demag_cmp_in, page_select, motor_regs_rst;
  logic cur_limit_evt, demag_evt, cur_blank_active, demag_blank_active;
  wire pwm_on_evt = strb[0];
  wire comm_evt = strb[1];
  wire pwm_off_end_evt = strb[2];
  wire hf_sample_tick = strb[3];
  int bad_count = 0, tests_run = 0, cyc = 0, rst_seen = 0, n, k, seed;
  int cl[4] = '{0, 7, 8, 15};
  mef_top u_mef_top (.*);
  mef_cmp_model u_cur_cmp (.aclk(aclk), .aresetn(aresetn), .level(cur_lvl),
    .chatter(chatter), .cmp_out(cur_cmp_in));
  mef_cmp_model u_dm_cmp (.aclk(aclk), .aresetn(aresetn), .level(dm_lvl),
    .chatter(1'b0), .cmp_out(demag_cmp_in));
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) begin
    if (motor_regs_rst === 1'b1) rst_seen <= rst_seen + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
    input logic [3:0] st, input mef_resp_type er);
    logic done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !lazy;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      else if (s_axi_bvalid) begin
        done = 1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ev,
    input mef_resp_type er);
    logic done;
    done = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !lazy;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      else if (s_axi_rvalid) begin
        done = 1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, ev});
        chk(s_axi_rresp, er);
      end
    end
  endtask
  task automatic pulse(input int b);
    @(posedge aclk);
    strb <= 4'h1 << b;
    @(posedge aclk);
    strb <= 4'h0;
  endtask
  task automatic smp(input int b);
    pulse(b);
    @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic lvl(input logic v);
    @(posedge aclk);
    dm_lvl <= v;
    repeat (3) @(posedge aclk);
  endtask
  task automatic blank(input int b, input int len, output int cnt);
    pulse(b);
    cnt = 0;
    repeat (len) begin
      @(negedge aclk);
      if ((b == 0 ? cur_blank_active : demag_blank_active) === 1'b1) cnt++;
    end
  endtask
  task automatic rst_vals;
    rd(8'h00, 8'h00, MEF_RESP_OKAY);
    rd(8'h04, 8'h0f, MEF_RESP_OKAY);
    rd(8'h08, 8'h00, MEF_RESP_OKAY);
  endtask
  // Window length in cycles of a 4 MHz clock, 4 cycles per microsecond
  function automatic int dm_cyc(input int c);
    return 4 * (c < 8 ? 5 * (c + 1) : 40 + 20 * (c - 7));
  endfunction
  initial begin
    seed = $urandom(32'hb0e9);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rst_vals();
    rd(8'h20, 8'h00, MEF_RESP_SLVERR);
    wr(8'h20, 8'h55, 4'h1, MEF_RESP_SLVERR);
    wr(8'h0c, 8'hff, 4'h1, MEF_RESP_OKAY);
    // Every other pass the master is slow to take answers
    repeat (4) begin
      lazy = !lazy;
      d = 8'($urandom);
      wr(8'h04, d, 4'h1, MEF_RESP_OKAY);
      rd(8'h04, d, MEF_RESP_OKAY);
      wr(8'h00, d & 8'hbf, 4'h1, MEF_RESP_OKAY);
      rd(8'h00, d & 8'hbf, MEF_RESP_OKAY);
      repeat (2) @(negedge aclk);
      chk(page_select, d[7]);
      wr(8'h08, d, 4'h0, MEF_RESP_OKAY);
      rd(8'h08, 8'h00, MEF_RESP_OKAY);
    end
    chk(rst_seen, 0);
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'(c << 3), 4'h1, MEF_RESP_OKAY);
      // Second pass after a dropout must take the full count again
      repeat (2) begin
        cur_lvl <= 1'b1;
        k = 0;
        while (cur_limit_evt !== 1'b1 && k < 60) begin
          @(negedge aclk);
          k++;
        end
        chk(k >= 4 * c + 5 && k <= 4 * c + 8, 1);
        @(posedge aclk);
        cur_lvl <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(cur_limit_evt, 0);
      end
    end
    wr(8'h00, 8'h08, 4'h1, MEF_RESP_OKAY);
    chatter <= 1'b1;
    k = 0;
    repeat (100) begin
      @(negedge aclk);
      if (cur_limit_evt === 1'b1) k++;
    end
    chk(k, 0);
    chatter <= 1'b0;
    wr(8'h00, 8'h07, 4'h1, MEF_RESP_OKAY);
    cur_lvl <= 1'b1;
    k = 0;
    repeat (6) begin
      pulse(0);
      repeat (10) begin
        @(negedge aclk);
        if (cur_limit_evt === 1'b1) k++;
      end
    end
    chk(k, 0);
    cur_lvl <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'(c), 4'h1, MEF_RESP_OKAY);
      blank(0, 20, n);
      chk(n, 2 * c);
    end
    foreach (cl[i]) begin
      wr(8'h04, 8'(cl[i]), 4'h1, MEF_RESP_OKAY);
      blank(1, 820, n);
      chk(n, dm_cyc(cl[i]));
    end
    wr(8'h04, 8'h00, 4'h1, MEF_RESP_OKAY);
    lvl(1);
    pulse(1);
    smp(2);
    chk(demag_evt, 0);
    repeat (25) @(posedge aclk);
    smp(2);
    chk(demag_evt, 1);
    foreach (cl[i]) begin
      k = (i == 1) ? int'($urandom_range(14, 1)) : cl[i];
      wr(8'h04, 8'(k << 4), 4'h1, MEF_RESP_OKAY);
      lvl(0);
      smp(2);
      lvl(1);
      repeat (k) smp(2);
      chk(demag_evt, 0);
      lvl(0);
      smp(2);
      lvl(1);
      repeat (k) smp(2);
      chk(demag_evt, 0);
      smp(2);
      chk(demag_evt, 1);
    end
    wr(8'h04, 8'h00, 4'h1, MEF_RESP_OKAY);
    wr(8'h08, 8'h02, 4'h1, MEF_RESP_OKAY);
    lvl(0);
    smp(3);
    lvl(1);
    smp(2);
    chk(demag_evt, 0);
    smp(3);
    chk(demag_evt, 1);
    wr(8'h04, 8'hff, 4'h1, MEF_RESP_OKAY);
    wr(8'h08, 8'h01, 4'h1, MEF_RESP_OKAY);
    lvl(0);
    lvl(1);
    @(posedge aclk);
    @(negedge aclk);
    chk(demag_evt, 1);
    blank(1, 100, n);
    chk(n, 0);
    rd(8'h0c, 8'h22, MEF_RESP_OKAY);
    wr(8'h04, 8'(seed), 4'h1, MEF_RESP_OKAY);
    wr(8'h00, 8'h80, 4'h1, MEF_RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk(page_select, 1);
    wr(8'h00, 8'hc0, 4'h1, MEF_RESP_OKAY);
    repeat (4) @(negedge aclk);
    chk(rst_seen, 1);
    chk(page_select, 0);
    rst_vals();
    wr(8'h04, 8'h33, 4'h1, MEF_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rst_vals();
    conclude();
  end
endmodule
bind mef_top mef_top_assertions u_mef_top_assertions (.*);
